// *** rsr_cfg.svh ***
// Purpose: constants of the reader status reporting block
// Assumes: 250 MHz controller clock
// Notes:   bit positions of both condition words and timing counts
`ifndef RSR_CFG_SVH
`define RSR_CFG_SVH
`define RSR_SEL_SYSTEM     2'h1
`define RSR_SEL_TRANSPORT  2'h2
`define RSR_SYS_READY      0
`define RSR_SYS_BUSY       1
`define RSR_SYS_INTR       2
`define RSR_SYS_DATA       3
`define RSR_SYS_EOP        4
`define RSR_SYS_ALARM      5
`define RSR_SYS_LOST       6
`define RSR_SYS_PROTECT    7
`define RSR_SYS_AUTOLOAD   8
`define RSR_SYS_LINE_DEL   9
`define RSR_SYS_REJECT     10
`define RSR_SYS_LL_FAIL    11
`define RSR_SYS_EOF        12
`define RSR_SYS_XPORT      13
`define RSR_SYS_NO_SORT    14
`define RSR_SYS_SKEW       15
`define RSR_TR_MIRROR_MSB  7
`define RSR_TR_MT_FAULT    9
`define RSR_TR_LEN_FAULT   10
`define RSR_TR_PARAM_FAULT 11
`define RSR_TR_COORD_FAULT 13
`define RSR_WORD_RESET     16'h0000
`define RSR_MAX_EXTRA_CHAR 2'h2
`define RSR_XFER_LIMIT_NS  500000
`define RSR_CLK_PERIOD_NS  4
`define RSR_XFER_LIMIT_CYC (`RSR_XFER_LIMIT_NS / `RSR_CLK_PERIOD_NS)
`define RSR_CTR_W          17
`endif

// *** rsr_pkg.sv ***
// Purpose: types of the reader status reporting block
// Assumes: nothing
// Notes:   operation sequencing states
package rsr_pkg;
    typedef enum logic [1:0] {
        RSR_IDLE,
        RSR_RUN,
        RSR_STOPPING
    } rsr_op_state_t;
endpackage

// *** rsr_flag_if.sv ***
// Purpose: bundle of shared set and clear terms and flag outputs for status flags
// Assumes: single clock domain
// Notes:   driven by the top, read by the flag bank
`timescale 1ns/1ps
interface rsr_flag_if;
    logic        clr_ctl;
    logic        clr_int;
    logic        mclr;
    logic        next_fn;
    logic [15:0] set_v;
    logic [15:0] clr_v;
    logic [15:0] flags;
    modport ctl  (output clr_ctl, clr_int, mclr, next_fn, set_v, clr_v,
                  input flags);
    modport bank (input clr_ctl, clr_int, mclr, next_fn, set_v, clr_v,
                  output flags);
endinterface

// *** rsr_flag_bank.sv ***
// Purpose: bank of sticky status flags, set wins over clear
// Assumes: set and clear vectors on the same clock
// Notes:   one flop per bit from a generate loop
`timescale 1ns/1ps
`include "rsr_cfg.svh"
module rsr_flag_bank (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // flag terms
    rsr_flag_if.bank fi
);
    logic [15:0] flag_ff;

    for (genvar i = 0; i < 16; i++) begin : g_flag
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                flag_ff[i] <= 1'b0;
            end else if (fi.set_v[i]) begin
                flag_ff[i] <= 1'b1;
            end else if (fi.clr_v[i]) begin
                flag_ff[i] <= 1'b0;
            end
        end
    end

    assign fi.flags = flag_ff;
endmodule

// *** rsr_status.sv ***
// Purpose: system and transport condition words for the host channel
// Assumes: panel and reader inputs are asynchronous pins
// Notes:   event inputs from controller logic are one-cycle pulses
`timescale 1ns/1ps
`include "rsr_cfg.svh"

module rsr_status (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // host channel
    input  wire logic [1:0]  fn_sel,
    input  wire logic        rd_strobe,
    output logic [15:0]      rd_data,
    input  wire logic        clr_ctl,
    input  wire logic        clr_int,
    input  wire logic        mclr,
    input  wire logic        fn_start,
    input  wire logic        xfer_done,
    input  wire logic        autoload_order,
    input  wire logic        sort_req,
    // controller events
    input  wire logic        op_done,
    input  wire logic        intr_sent,
    input  wire logic        data_ready,
    input  wire logic        autoload_done,
    input  wire logic        line_delete,
    input  wire logic        reject_code,
    input  wire logic        ll_fail,
    input  wire logic        no_sort,
    input  wire logic        skewed,
    input  wire logic        mt_fault,
    input  wire logic        len_fault,
    input  wire logic        param_fault,
    input  wire logic        autoload_req,
    input  wire logic        char_ready,
    input  wire logic        char_taken,
    input  wire logic [7:0]  sweep_start_coordinate,
    input  wire logic [7:0]  sweep_end_coordinate,
    input  wire logic        coord_check,
    input  wire logic [7:0]  zone_lo,
    input  wire logic [7:0]  zone_hi,
    input  wire logic        doc_positioned,
    input  wire logic [7:0]  mirror_pos,
    input  wire logic        mirror_upd,
    input  wire logic        mirror_in_scan,
    // reader and panel pins
    input  wire logic        mech_ready_pin,
    input  wire logic        elec_ready_pin,
    input  wire logic        ready_btn_pin,
    input  wire logic        stop_btn_pin,
    input  wire logic        eof_btn_pin,
    input  wire logic        protect_pin,
    input  wire logic        late_char_pin,
    // to controller
    output logic             ready,
    output logic             busy,
    output logic             alarm_irq,
    output logic             fn_refused
);
    logic [6:0]  s1_ff;
    logic [6:0]  s2_ff;
    logic [6:0]  s3_ff;
    logic        mech_r, elec_r, rbtn_r, stop_r, eof_r, prot_r, late_r;
    logic        rbtn_rise, stop_rise, eof_rise, late_rise;
    logic        ready_ff, armed_ff;
    logic        ready_cond, ready_lost;
    rsr_pkg::rsr_op_state_t state_ff;
    rsr_pkg::rsr_op_state_t nxt_state;
    logic [`RSR_CTR_W-1:0] xfer_ctr_ff;
    logic        xfer_late;
    logic [1:0]  extra_ff;
    logic        coord_bad;
    logic [7:0]  mirror_ff;
    logic [15:0] sys_word, tr_word;
    logic        next_fn;
    logic [15:0] set_v, clr_v;
    logic [15:0] flags;

    // pin synchronisers, second stage feeds levels, second and third stages feed edge detection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_ff <= 7'h00;
            s2_ff <= 7'h00;
            s3_ff <= 7'h00;
        end else begin
            s1_ff <= {late_char_pin, protect_pin, eof_btn_pin,
                      stop_btn_pin, ready_btn_pin, elec_ready_pin,
                      mech_ready_pin};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    assign {late_r, prot_r, eof_r, stop_r, rbtn_r, elec_r, mech_r} = s2_ff;
    assign rbtn_rise = s2_ff[2] & ~s3_ff[2];
    assign stop_rise = s2_ff[3] & ~s3_ff[3];
    assign eof_rise  = s2_ff[4] & ~s3_ff[4];
    assign late_rise = s2_ff[6] & ~s3_ff[6];

    // coordinate check refuses a bad function
    assign coord_bad = coord_check &&
        (sweep_start_coordinate < zone_lo ||
         sweep_end_coordinate > zone_hi ||
         sweep_start_coordinate > sweep_end_coordinate);
    assign fn_refused = coord_bad;
    assign next_fn = fn_start && !coord_bad;

    // operation sequencing
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            rsr_pkg::RSR_IDLE: begin
                if (next_fn) begin
                    nxt_state = rsr_pkg::RSR_RUN;
                end
            end
            rsr_pkg::RSR_RUN: begin
                if (op_done) begin
                    nxt_state = rsr_pkg::RSR_IDLE;
                end else if (stop_rise) begin
                    nxt_state = rsr_pkg::RSR_STOPPING;
                end
            end
            rsr_pkg::RSR_STOPPING: begin
                if (op_done) begin
                    nxt_state = rsr_pkg::RSR_IDLE;
                end
            end
        endcase
        if (clr_ctl || mclr) begin
            nxt_state = rsr_pkg::RSR_IDLE;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= rsr_pkg::RSR_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end
    assign busy = (state_ff != rsr_pkg::RSR_IDLE);

    // ready bit
    assign ready_cond = mech_r && elec_r && doc_positioned;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            armed_ff <= 1'b0;
        end else if (!ready_cond || (stop_rise && !busy) ||
                     (state_ff == rsr_pkg::RSR_STOPPING && op_done)) begin
            armed_ff <= 1'b0;
        end else if (rbtn_rise) begin
            armed_ff <= 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ready_ff <= 1'b0;
        end else if (!ready_cond) begin
            ready_ff <= 1'b0;
        end else if (stop_rise && !busy) begin
            ready_ff <= 1'b0;
        end else if (state_ff == rsr_pkg::RSR_STOPPING && op_done) begin
            ready_ff <= 1'b0;
        end else if (armed_ff || rbtn_rise) begin
            ready_ff <= 1'b1;
        end
    end
    assign ready = ready_ff;
    assign ready_lost = ready_ff && !(ready_cond && !(stop_rise && !busy)
        && !(state_ff == rsr_pkg::RSR_STOPPING && op_done));

    // data transfer watchdog, counts while data bit stands
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xfer_ctr_ff <= '0;
        end else if (!flags[`RSR_SYS_DATA] || xfer_done) begin
            xfer_ctr_ff <= '0;
        end else if (!xfer_late) begin
            xfer_ctr_ff <= xfer_ctr_ff + 1'b1;
        end
    end
    assign xfer_late = flags[`RSR_SYS_DATA] && !xfer_done &&
        (xfer_ctr_ff == `RSR_CTR_W'(`RSR_XFER_LIMIT_CYC - 1));

    // unserviced characters: one pending plus two extra
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            extra_ff <= 2'h0;
        end else if (next_fn || clr_ctl || mclr) begin
            extra_ff <= 2'h0;
        end else if (char_ready && !char_taken &&
                     extra_ff != `RSR_MAX_EXTRA_CHAR + 2'h1) begin
            extra_ff <= extra_ff + 2'h1;
        end else if (char_taken && !char_ready && extra_ff != 2'h0) begin
            extra_ff <= extra_ff - 2'h1;
        end
    end

    // mirror coordinate, previous value kept while updating
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mirror_ff <= 8'h00;
        end else if (!mirror_in_scan) begin
            mirror_ff <= 8'h00;
        end else if (!mirror_upd) begin
            mirror_ff <= mirror_pos;
        end
    end

    // flag set terms
    logic lost_set, tsf_set, alarm_set;
    assign lost_set = xfer_late || late_rise ||
        (char_ready && extra_ff == `RSR_MAX_EXTRA_CHAR + 2'h1);
    assign tsf_set = mt_fault || len_fault || param_fault || coord_bad;
    assign alarm_set = ready_lost || lost_set || tsf_set || ll_fail ||
        autoload_req || no_sort || skewed;

    always_comb begin
        set_v = 16'h0000;
        set_v[`RSR_SYS_INTR]     = intr_sent;
        set_v[`RSR_SYS_DATA]     = data_ready;
        set_v[`RSR_SYS_EOP]      = busy && (nxt_state ==
                                   rsr_pkg::RSR_IDLE) && op_done;
        set_v[`RSR_SYS_ALARM]    = alarm_set;
        set_v[`RSR_SYS_LOST]     = lost_set;
        set_v[`RSR_SYS_AUTOLOAD] = autoload_order;
        set_v[`RSR_SYS_LINE_DEL] = line_delete;
        set_v[`RSR_SYS_REJECT]   = reject_code;
        set_v[`RSR_SYS_LL_FAIL]  = ll_fail;
        set_v[`RSR_SYS_EOF]      = eof_rise && !ready_ff &&
                                   !flags[`RSR_SYS_EOF];
        set_v[`RSR_SYS_XPORT]    = tsf_set;
        set_v[`RSR_SYS_NO_SORT]  = no_sort;
        set_v[`RSR_SYS_SKEW]     = skewed;
    end

    // flag clear terms; next function clears in its own cycle
    logic base_clr;
    assign base_clr = clr_ctl || mclr || next_fn;
    always_comb begin
        clr_v = {16{base_clr}};
        clr_v[`RSR_SYS_INTR]     = clr_ctl || clr_int;
        clr_v[`RSR_SYS_DATA]     = clr_ctl || clr_int || xfer_done;
        clr_v[`RSR_SYS_EOP]      = clr_ctl || clr_int || next_fn;
        clr_v[`RSR_SYS_AUTOLOAD] = autoload_done;
        clr_v[`RSR_SYS_EOF]      = clr_ctl || mclr || clr_int ||
                                   rbtn_rise ||
                                   (eof_rise && flags[`RSR_SYS_EOF]);
        clr_v[`RSR_SYS_NO_SORT]  = base_clr || sort_req;
    end

    // transport faults kept in their own four flops, outside the bank
    logic [3:0] tr_ff;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tr_ff <= 4'h0;
        end else begin
            if (mt_fault) tr_ff[0] <= 1'b1;
            else if (base_clr) tr_ff[0] <= 1'b0;
            if (len_fault) tr_ff[1] <= 1'b1;
            else if (clr_ctl || mclr || (ready_cond && rbtn_rise))
                tr_ff[1] <= 1'b0;
            if (param_fault) tr_ff[2] <= 1'b1;
            else if (base_clr) tr_ff[2] <= 1'b0;
            if (coord_bad) tr_ff[3] <= 1'b1;
            else if (base_clr) tr_ff[3] <= 1'b0;
        end
    end

    rsr_flag_if fi ();
    assign fi.clr_ctl = clr_ctl;
    assign fi.clr_int = clr_int;
    assign fi.mclr    = mclr;
    assign fi.next_fn = next_fn;
    assign fi.set_v   = set_v;
    assign fi.clr_v   = clr_v;
    assign flags      = fi.flags;

    rsr_flag_bank u_bank (
        .clk  (clk),
        .rstn (rstn),
        .fi   (fi)
    );

    // assembled words
    always_comb begin
        sys_word = flags;
        sys_word[`RSR_SYS_READY]   = ready_ff;
        sys_word[`RSR_SYS_BUSY]    = busy;
        sys_word[`RSR_SYS_PROTECT] = prot_r;
        tr_word = `RSR_WORD_RESET;
        tr_word[`RSR_TR_MIRROR_MSB:0]  = mirror_ff;
        tr_word[`RSR_TR_MT_FAULT]      = tr_ff[0];
        tr_word[`RSR_TR_LEN_FAULT]     = tr_ff[1];
        tr_word[`RSR_TR_PARAM_FAULT]   = tr_ff[2];
        tr_word[`RSR_TR_COORD_FAULT]   = tr_ff[3];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data <= `RSR_WORD_RESET;
        end else if (rd_strobe && fn_sel == `RSR_SEL_SYSTEM) begin
            rd_data <= sys_word;
        end else if (rd_strobe && fn_sel == `RSR_SEL_TRANSPORT) begin
            rd_data <= tr_word;
        end
    end
    assign alarm_irq = flags[`RSR_SYS_ALARM];

    // checks
    property p_read_sys;
        @(posedge clk) disable iff (!rstn)
        rd_strobe && fn_sel == `RSR_SEL_SYSTEM |=> rd_data == $past(sys_word);
    endproperty
    a_read_sys: assert property (p_read_sys) else $error("bad sys read");

    property p_busy_start;
        @(posedge clk) disable iff (!rstn)
        next_fn && !busy && !clr_ctl && !mclr |=> busy;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("no busy");

    sequence s_done;
        busy && op_done && !clr_ctl && !mclr;
    endsequence
    property p_eop;
        @(posedge clk) disable iff (!rstn)
        s_done |=> !busy && flags[`RSR_SYS_EOP];
    endproperty
    a_eop: assert property (p_eop) else $error("eop missing");

    property p_intr_hold;
        @(posedge clk) disable iff (!rstn)
        flags[`RSR_SYS_INTR] && !clr_ctl && !clr_int
            |=> flags[`RSR_SYS_INTR];
    endproperty
    a_intr_hold: assert property (p_intr_hold) else $error("intr lost");

    property p_late;
        @(posedge clk) disable iff (!rstn)
        xfer_late |=> flags[`RSR_SYS_LOST] && flags[`RSR_SYS_ALARM];
    endproperty
    a_late: assert property (p_late) else $error("late xfer");

    property p_coord;
        @(posedge clk) disable iff (!rstn)
        fn_start && coord_bad && !busy |=> !busy && tr_word[13];
    endproperty
    a_coord: assert property (p_coord) else $error("coord fault");

    property p_next_clr;
        @(posedge clk) disable iff (!rstn)
        next_fn && !set_v[`RSR_SYS_SKEW] |=> !flags[`RSR_SYS_SKEW];
    endproperty
    a_next_clr: assert property (p_next_clr) else $error("no clear");

    property p_ready_loss;
        @(posedge clk) disable iff (!rstn)
        ready_ff && !ready_cond |=> !ready_ff && flags[`RSR_SYS_ALARM];
    endproperty
    a_ready_loss: assert property (p_ready_loss) else $error("ready");
endmodule

// *** rsr_host_model.sv ***
// Purpose: host channel model issuing reads and control pulses
// Assumes: requests change at the falling edge of clk
// Notes:   one request at a time; control pulses last one cycle
`timescale 1ns/1ps
module rsr_host_model (
    // clock
    input  wire logic        clk,
    // read channel
    output logic [1:0]       fn_sel,
    output logic             rd_strobe,
    input  wire logic [15:0] rd_data,
    // clr_ctl clr_int mclr fn_start xfer_done autoload_order sort_req
    output logic [6:0]       hp
);
    initial begin
        fn_sel    = 2'h0;
        rd_strobe = 1'h0;
        hp        = 7'h00;
    end

    // select held with the strobe across the taking edge
    task automatic rd(input logic [1:0] s, output logic [15:0] d);
        @(negedge clk);
        fn_sel    = s;
        rd_strobe = 1'h1;
        @(negedge clk);
        rd_strobe = 1'h0;
        fn_sel    = 2'h0;
        d         = rd_data;
    endtask

    // one-cycle pulse on the control line selected by i
    task automatic pulse(input int i);
        @(negedge clk);
        hp[i] = 1'h1;
        @(negedge clk);
        hp[i] = 1'h0;
    endtask
endmodule

// *** rsr_status_tb_top.sv ***
// Purpose: self-checking bench of the status reporting block
// Assumes: host model drives the channel, bench drives the rest
// Notes:   checks are masked to the bits each step is about
`timescale 1ns/1ps
module rsr_status_tb_top;
    logic        clk;
    logic        rstn;
    logic [1:0]  fn_sel;
    logic        rd_strobe;
    logic [15:0] rd_data;
    logic [6:0]  hp;
    logic [14:0] ev;
    logic [6:0]  pins;
    logic [7:0]  st_c;
    logic [7:0]  end_c;
    logic [7:0]  mpos;
    logic        coord_check;
    logic [7:0]  zlo;
    logic [7:0]  zhi;
    logic        doc_pos;
    logic        m_upd;
    logic        m_in;
    logic        ready;
    logic        busy;
    logic        alarm_irq;
    logic        fn_refused;
    logic        refused_seen;
    int          fails;
    int          n_tests;
    // event, word select, set mask, clearing pulse, cleared mask
    int          ev_i[11] = '{1, 2, 4, 5, 6, 7, 8, 9, 10, 11, 12};
    logic [1:0]  ev_s[11] = '{1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 1};
    logic [15:0] ev_m[11] = '{16'h0004, 16'h0008, 16'h0200, 16'h0400,
        16'h0820, 16'h4020, 16'h8020, 16'h0200, 16'h0400, 16'h0800,
        16'h0020};
    int          ev_c[11] = '{1, 4, 0, 2, 0, 6, 2, 0, 2, 0, 0};
    logic [15:0] ev_k[11] = '{16'h0004, 16'h0008, 16'h0200, 16'h0400,
        16'h0820, 16'h4000, 16'h8020, 16'h0200, 16'h0400, 16'h0800,
        16'h0020};

    rsr_host_model host_u (
        .clk       (clk),
        .fn_sel    (fn_sel),
        .rd_strobe (rd_strobe),
        .rd_data   (rd_data),
        .hp        (hp)
    );

    rsr_status dut_u (
        .clk (clk), .rstn (rstn),
        .fn_sel (fn_sel), .rd_strobe (rd_strobe), .rd_data (rd_data),
        .clr_ctl (hp[0]), .clr_int (hp[1]), .mclr (hp[2]),
        .fn_start (hp[3]), .xfer_done (hp[4]),
        .autoload_order (hp[5]), .sort_req (hp[6]),
        .op_done (ev[0]), .intr_sent (ev[1]), .data_ready (ev[2]),
        .autoload_done (ev[3]), .line_delete (ev[4]),
        .reject_code (ev[5]), .ll_fail (ev[6]), .no_sort (ev[7]),
        .skewed (ev[8]), .mt_fault (ev[9]), .len_fault (ev[10]),
        .param_fault (ev[11]), .autoload_req (ev[12]),
        .char_ready (ev[13]), .char_taken (ev[14]),
        .sweep_start_coordinate (st_c), .sweep_end_coordinate (end_c),
        .coord_check (coord_check), .zone_lo (zlo), .zone_hi (zhi),
        .doc_positioned (doc_pos), .mirror_pos (mpos),
        .mirror_upd (m_upd), .mirror_in_scan (m_in),
        .mech_ready_pin (pins[0]), .elec_ready_pin (pins[1]),
        .ready_btn_pin (pins[2]), .stop_btn_pin (pins[3]),
        .eof_btn_pin (pins[4]), .protect_pin (pins[5]),
        .late_char_pin (pins[6]),
        .ready (ready), .busy (busy), .alarm_irq (alarm_irq),
        .fn_refused (fn_refused)
    );

    always #2 clk = ~clk;

    always @(posedge clk) begin
        if (hp[3]) begin
            refused_seen <= fn_refused;
        end
    end

    task automatic wrap_up;
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rc(input logic [1:0] s, input logic [15:0] m,
                      input logic [15:0] exp);
        logic [15:0] d;
        host_u.rd(s, d);
        chk(d & m, exp);
    endtask

    task automatic evp(input int i);
        @(negedge clk);
        ev[i] = 1'h1;
        @(negedge clk);
        ev[i] = 1'h0;
    endtask

    // pins pass a two-flop sync before edge detection
    task automatic pp(input int i);
        @(negedge clk);
        pins[i] = 1'h1;
        repeat (6) @(negedge clk);
        pins[i] = 1'h0;
        repeat (6) @(negedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        wrap_up();
    end

    initial begin
        clk = 1'h0; rstn = 1'h0; ev = 15'h0000; pins = 7'h00;
        st_c = 8'h00; end_c = 8'h00; mpos = 8'h00; coord_check = 1'h0;
        doc_pos = 1'h0; m_upd = 1'h0; m_in = 1'h0; refused_seen = 1'h0;
        fails = 0; n_tests = 0; zlo = 8'h10; zhi = 8'hF0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rstn = 1'h1;
        rc(2'h1, 16'hFFFF, 16'h0000);
        rc(2'h2, 16'hFFFF, 16'h0000);
        for (int k = 0; k < 11; k++) begin
            evp(ev_i[k]);
            rc(ev_s[k], ev_m[k], ev_m[k]);
            host_u.pulse(ev_c[k]);
            rc(ev_s[k], ev_k[k], 16'h0000);
        end
        evp(9);
        rc(2'h1, 16'h2020, 16'h2020);
        host_u.pulse(2);
        rc(2'h1, 16'h2020, 16'h0000);
        pins[1:0] = 2'h3;
        doc_pos = 1'h1;
        pp(2);
        rc(2'h1, 16'h0001, 16'h0001);
        host_u.pulse(3);
        rc(2'h1, 16'h0002, 16'h0002);
        pp(3);
        rc(2'h1, 16'h0003, 16'h0003);
        evp(0);
        rc(2'h1, 16'h0033, 16'h0030);
        chk({15'h0000, ready}, 16'h0000);
        host_u.pulse(3);
        rc(2'h1, 16'h0032, 16'h0002);
        evp(0);
        pp(4);
        rc(2'h1, 16'h1000, 16'h1000);
        pp(4);
        rc(2'h1, 16'h1000, 16'h0000);
        pins[5] = 1'h1;
        rc(2'h1, 16'h0010, 16'h0010);
        rc(2'h1, 16'h0080, 16'h0080);
        host_u.pulse(5);
        rc(2'h1, 16'h0100, 16'h0100);
        evp(3);
        rc(2'h1, 16'h0100, 16'h0000);
        pp(6);
        rc(2'h1, 16'h0060, 16'h0060);
        host_u.pulse(0);
        repeat (3) evp(13);
        evp(14);
        evp(13);
        rc(2'h1, 16'h0040, 16'h0000);
        evp(13);
        rc(2'h1, 16'h0060, 16'h0060);
        coord_check = 1'h1; st_c = 8'h40; end_c = 8'h30;
        host_u.pulse(3);
        chk({15'h0000, refused_seen}, 16'h0001);
        rc(2'h1, 16'h0002, 16'h0000);
        rc(2'h2, 16'h2000, 16'h2000);
        st_c = 8'h20; end_c = 8'h40; zhi = 8'h38;
        host_u.pulse(3);
        chk({15'h0000, refused_seen}, 16'h0001);
        zhi = 8'hF0; zlo = 8'h28;
        host_u.pulse(3);
        chk({15'h0000, refused_seen}, 16'h0001);
        zlo = 8'h10;
        host_u.pulse(3);
        chk({15'h0000, refused_seen}, 16'h0000);
        rc(2'h2, 16'h2000, 16'h0000);
        evp(0);
        coord_check = 1'h0; m_in = 1'h1; mpos = 8'h5A;
        rc(2'h2, 16'h00FF, 16'h005A);
        m_upd = 1'h1; mpos = 8'h77;
        rc(2'h2, 16'h00FF, 16'h005A);
        m_upd = 1'h0;
        rc(2'h2, 16'h00FF, 16'h0077);
        m_in = 1'h0;
        rc(2'h2, 16'h00FF, 16'h0000);
        pp(2);
        rc(2'h1, 16'h0021, 16'h0001);
        doc_pos = 1'h0;
        rc(2'h1, 16'h0021, 16'h0020);
        wrap_up();
    end
endmodule
